// *** rtl/quad_dac_serial_write_port.sv ***
// Module: serial write port and register state of a quad DAC
// Contract
// - The port has only frame select, serial clock and data in; no readback.
// - A falling frame select starts a new word.
// - Data is sampled on each falling serial clock edge into 24 bits.
// - The 24th falling edge takes the last bit and runs the command.
// - Serial clock up to 50 MHz is allowed; the port samples pins on clk and needs below clk/6, and the host keeps below that.
// - The internal reference is off after reset until written on.
// - DAC codes are straight binary, zeros zero scale, ones full scale.
// - Valid code span depends on resolution: 12, 14 or 16 bits.
// - Frame select rising before edge 24 discards the frame.
// - Word is MSB first: 2 ignored, 3 command, 3 address, data.
// - Address 0 to 3 picks channel A to D; all ones picks all four.
// - Command 100 sets power state; 101 resets, DB0 choosing full.
`timescale 1ns/1ps
module quad_dac_serial_write_port
#(
   parameter int RES_BITS = 16
)
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Serial port pins
   input  wire logic                syncn,
   input  wire logic                sclk,
   input  wire logic                din,
   // Hardware load strobe, active low
   input  wire logic                loadAllChannelsn,
   // Channel state
   output logic [4*RES_BITS-1:0]    dacCode,
   output logic [4*RES_BITS-1:0]    inputCode,
   output logic [7:0]               powerMode,
   output logic [3:0]               loadTransparent,
   output logic                     referencePin
);
   logic [1:0] rstSh;
   logic       rstn;
   logic [2:0] ldSh;
   logic       ldLvl;
   frame_if    frm ();

   // Reset released through two flops
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rstSh <= 2'b00;
      else
         rstSh <= {rstSh[0], 1'b1};
   end
   assign rstn = rstSh[1];

   // Only the three inputs reach the shifter; nothing is read back
   // Pins are sampled by clk, so the link must stay below clk/6
   // Limitation: far short of the full-speed pin-level serial clock
   serial_shifter u_shift
   (
      .clk   (clk),
      .rstn  (rstn),
      .syncn (syncn),
      .sclk  (sclk),
      .din   (din),
      .frm   (frm)
   );

   // External load pin also crosses three stages
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ldSh  <= 3'h7;
         ldLvl <= 1'b1;
      end
      else
      begin
         ldSh <= {ldSh[1:0], loadAllChannelsn};
         if (ldSh[1] == ldSh[2])
            ldLvl <= ldSh[2];
      end
   end

   // Field split of the word, MSB first
   wire [2:0]  cmd  = frm.word[dac_port_pkg::CMD_MSB -: 3];
   wire [2:0]  addr = frm.word[dac_port_pkg::ADDR_MSB -: 3];
   // Low resolutions drop trailing ignored bits
   wire [RES_BITS-1:0] code =
      frm.word[dac_port_pkg::DATA_MSB -: RES_BITS];

   function automatic logic hitChan(input logic [2:0] a, input int ch);
      hitChan = (a == dac_port_pkg::ADDR_ALL) || (a == 3'(ch));
   endfunction

   // True in the one cycle that runs the given command
   function automatic logic runs(input logic       e,
                                 input logic [2:0] c,
                                 input logic [2:0] op);
      runs = e && (c == op);
   endfunction

   wire exec     = frm.done;
   wire fullRst  = runs(exec, cmd, dac_port_pkg::CMD_RESET) && frm.word[0];
   wire partRst  = runs(exec, cmd, dac_port_pkg::CMD_RESET);
   // Load pin is a level: it keeps copying for as long as it is held
   wire ldActive = !ldLvl;

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_chan
         wire                 hit    = hitChan(addr, g);
         wire [RES_BITS-1:0]  staged = inputCode[g*RES_BITS +: RES_BITS];
         logic [RES_BITS-1:0] next_staged;
         logic [RES_BITS-1:0] next_active;

         // Priority: soft reset, then the frame's command, then load pin
         always_comb
         begin
            next_staged = staged;
            next_active = dacCode[g*RES_BITS +: RES_BITS];
            if (ldActive)
               next_active = staged;
            if (partRst)
            begin
               next_staged = '0;
               next_active = '0;
            end
            else if (exec)
            begin
               case (cmd)
                  dac_port_pkg::CMD_WR_IN:
                  begin
                     if (hit)
                        next_staged = code;
                     if (hit && loadTransparent[g])
                        next_active = code;
                  end
                  dac_port_pkg::CMD_UPD:
                  begin
                     if (hit)
                        next_active = staged;
                  end
                  dac_port_pkg::CMD_WR_UPDALL:
                  begin
                     if (hit)
                        next_staged = code;
                     // Addressed channel takes the fresh code directly
                     next_active = hit ? code : staged;
                  end
                  dac_port_pkg::CMD_WR_UPD:
                  begin
                     if (hit)
                     begin
                        next_staged = code;
                        next_active = code;
                     end
                  end
                  default: ;
               endcase
            end
         end

         // Codes stored unsigned; zero is zero scale
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               inputCode[g*RES_BITS +: RES_BITS] <= '0;
               dacCode[g*RES_BITS +: RES_BITS]   <= '0;
            end
            else
            begin
               inputCode[g*RES_BITS +: RES_BITS] <= next_staged;
               dacCode[g*RES_BITS +: RES_BITS]   <= next_active;
            end
         end

         // Power state: DB5:DB4 mode, DB3..DB0 channel select
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               powerMode[2*g +: 2] <= dac_port_pkg::PWR_RESET;
            else if (fullRst)
               powerMode[2*g +: 2] <= dac_port_pkg::PWR_RESET;
            else if (runs(exec, cmd, dac_port_pkg::CMD_PWR) && frm.word[g])
               powerMode[2*g +: 2] <= frm.word[5:4];
         end

         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               loadTransparent[g] <= 1'b0;
            else if (fullRst)
               loadTransparent[g] <= 1'b0;
            else if (runs(exec, cmd, dac_port_pkg::CMD_LOADSETUP))
               loadTransparent[g] <= frm.word[g];
         end
      end
   endgenerate

   // Reference off until a setup write; DB0 turns it on
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         referencePin <= 1'b0;
      else if (fullRst)
         referencePin <= 1'b0;
      else if (runs(exec, cmd, dac_port_pkg::CMD_REFSETUP))
         referencePin <= frm.word[0];
   end
endmodule

// *** rtl/dac_port_pkg.sv ***
// Package: constants for the quad DAC serial write port
package dac_port_pkg;
   localparam int FRAME_BITS     = 24;
   localparam int CMD_MSB        = 21;
   localparam int ADDR_MSB       = 18;
   localparam int DATA_MSB       = 15;
   localparam int SYNC_STAGES    = 3;
   localparam int LINK_MAX_MHZ   = 50;
   localparam int CLK_MHZ        = 25;
   localparam logic [2:0] CMD_WR_IN     = 3'h0;
   localparam logic [2:0] CMD_UPD       = 3'h1;
   localparam logic [2:0] CMD_WR_UPDALL = 3'h2;
   localparam logic [2:0] CMD_WR_UPD    = 3'h3;
   localparam logic [2:0] CMD_PWR       = 3'h4;
   localparam logic [2:0] CMD_RESET     = 3'h5;
   localparam logic [2:0] CMD_LOADSETUP = 3'h6;
   localparam logic [2:0] CMD_REFSETUP  = 3'h7;
   localparam logic [2:0] ADDR_ALL      = 3'h7;
   localparam logic [15:0] CODE_RESET   = 16'h0000;
   localparam logic [1:0]  PWR_RESET    = 2'h0;
endpackage

// *** rtl/frame_if.sv ***
// Interface: decoded frame passed from the shifter to the executor
`timescale 1ns/1ps
interface frame_if;
   logic        done;
   logic [23:0] word;
   modport source (output done, output word);
   modport sink   (input done, input word);
endinterface

// *** rtl/serial_shifter.sv ***
// Module: samples the three port pins and assembles 24-bit frames
`timescale 1ns/1ps
module serial_shifter
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Port pins
   input  wire logic syncn,
   input  wire logic sclk,
   input  wire logic din,
   // Frame out
   frame_if.source   frm
);
   logic [2:0]  syncSh;
   logic [2:0]  sclkSh;
   logic [2:0]  dinSh;
   logic        syncLvl;
   logic        sclkLvl;
   logic        armed;
   logic        active;
   logic [4:0]  count;
   logic [23:0] shift;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         syncSh <= 3'h7;
         sclkSh <= 3'h0;
         dinSh  <= 3'h0;
      end
      else
      begin
         syncSh <= {syncSh[1:0], syncn};
         sclkSh <= {sclkSh[1:0], sclk};
         dinSh  <= {dinSh[1:0], din};
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         syncLvl <= 1'b1;
         sclkLvl <= 1'b0;
      end
      else
      begin
         if (syncSh[1] == syncSh[2])
            syncLvl <= syncSh[2];
         if (sclkSh[1] == sclkSh[2])
            sclkLvl <= sclkSh[2];
      end
   end

   wire syncFall = syncLvl && (syncSh[1] == syncSh[2]) && !syncSh[2];
   wire syncRise = !syncLvl && (syncSh[1] == syncSh[2]) && syncSh[2];
   wire sclkFall = sclkLvl && (sclkSh[1] == sclkSh[2]) && !sclkSh[2];

   // Word lives only while framed; a rise discards it
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         armed    <= 1'b1;
         active   <= 1'b0;
         count    <= 5'h0;
         shift    <= 24'h0000;
         frm.done <= 1'b0;
         frm.word <= 24'h0000;
      end
      else
      begin
         frm.done <= 1'b0;
         if (syncRise)
         begin
            active <= 1'b0;
            armed  <= 1'b1;
            count  <= 5'h0;
            shift  <= 24'h0000;
         end
         else if (syncFall && armed)
         begin
            active <= 1'b1;
            armed  <= 1'b0;
            count  <= 5'h0;
            shift  <= 24'h0000;
         end
         else if (active && sclkFall)
         begin
            shift <= {shift[22:0], dinSh[2]};
            if (count == 5'(dac_port_pkg::FRAME_BITS - 1))
            begin
               frm.done <= 1'b1;
               frm.word <= {shift[22:0], dinSh[2]};
               active   <= 1'b0;
               count    <= 5'h0;
            end
            else
               count <= count + 5'h1;
         end
      end
   end
endmodule

// *** dv/quad_dac_port_assertions.sv ***
// Checker: port-level properties of the DAC write port
`timescale 1ns/1ps
module quad_dac_port_assertions
#(
   parameter int RES_BITS = 16
)
(
   // Watched ports
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  syncn,
   input wire logic                  sclk,
   input wire logic                  din,
   input wire logic                  loadAllChannelsn,
   input wire logic [4*RES_BITS-1:0] dacCode,
   input wire logic [4*RES_BITS-1:0] inputCode,
   input wire logic [7:0]            powerMode,
   input wire logic [3:0]            loadTransparent,
   input wire logic                  referencePin
);
   logic       sclkQ;
   logic [3:0] sinceFall;
   // Saturating count of clocks since a raw serial clock fall
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclkQ     <= 1'b1;
         sinceFall <= 4'hF;
      end
      else
      begin
         sclkQ     <= sclk;
         sinceFall <= (sclkQ && !sclk) ? 4'h0
                      : sinceFall + {3'h0, sinceFall != 4'hF};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence quietPins;
      (syncn && loadAllChannelsn)[*8];
   endsequence
   // Pin filter and level register take five clocks to reach the codes
   sequence loadHeld;
      (!loadAllChannelsn && $stable(inputCode))[*6];
   endsequence
   idle_outputs_a: assert property (quietPins |-> $stable({dacCode,
      inputCode, powerMode, loadTransparent, referencePin}))
      else $error("outputs moved with no frame");
   reset_state_a: assert property ($rose(resetn) |->
      !referencePin && powerMode == 8'h00) else $error("reset state wrong");
   update_after_a: assert property ((!$stable(inputCode)
      || !$stable(powerMode) || !$stable(referencePin)
      || !$stable(loadTransparent)) |-> sinceFall <= 4'h8)
      else $error("update far from a clock fall");
   load_copy_a: assert property (loadHeld |-> dacCode == inputCode)
      else $error("load strobe did not copy codes");
   ref_once_a: assert property (!$stable(referencePin)
      |=> $stable(referencePin)[*8]) else $error("reference moved twice");
   pwr_once_a: assert property (!$stable(powerMode)
      |=> $stable(powerMode)[*8]) else $error("power moved twice");
   lt_once_a: assert property (!$stable(loadTransparent)
      |=> $stable(loadTransparent)[*8]) else $error("setup moved twice");
   code_once_a: assert property (!$stable(inputCode)
      |=> $stable(inputCode)[*8]) else $error("input code moved twice");
endmodule
bind quad_dac_serial_write_port quad_dac_port_assertions
   #(.RES_BITS(RES_BITS)) chk (.clk(clk), .resetn(resetn), .syncn(syncn),
   .sclk(sclk), .din(din), .loadAllChannelsn(loadAllChannelsn),
   .dacCode(dacCode), .inputCode(inputCode), .powerMode(powerMode),
   .loadTransparent(loadTransparent), .referencePin(referencePin));

// *** dv/host_model.sv ***
// Host model: drives frames onto the three port pins
`timescale 1ns/1ps
module host_model
(
   // Clock
   input  wire logic clk,
   // Port pins
   output logic      syncn,
   output logic      sclk,
   output logic      din
);
   initial
   begin
      syncn = 1'b1;
      sclk  = 1'b1;
      din   = 1'b0;
   end
   // Falls past 24 carry toggling filler
   task automatic send(input logic [23:0] w, input int n);
      @(posedge clk) syncn <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         din <= (i < 24) ? w[23-i] : !din;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      syncn <= 1'b1;
      din   <= !din;
   endtask
endmodule

// *** dv/tb.sv ***
// Testbench: frames against a behavioural model of the DAC port
`timescale 1ns/1ps
module tb;
   logic         clk;
   logic         resetn;
   logic         loadAllChannelsn;
   logic         syncn;
   logic         sclk;
   logic         din;
   logic [63:0]  dacCode;
   logic [63:0]  inputCode;
   logic [7:0]   powerMode;
   logic [3:0]   loadTransparent;
   logic         referencePin;
   int           n_fail;
   int           compares;
   logic [15:0]  mIn [4];
   logic [15:0]  mDac [4];
   logic [1:0]   mPm [4];
   logic [3:0]   mLt;
   logic         mRef;
   logic [23:0]  v;
   logic [23:0]  plan [12] = '{24'h38_0001, 24'h18_FFFF, 24'h1B_0000,
      24'h01_1234, 24'h09_0000, 24'h17_7FFF, 24'h30_0005, 24'h02_ABCD,
      24'h20_0029, 24'h28_0000, 24'h1F_5555, 24'h28_0001};
   quad_dac_serial_write_port dut (.clk(clk), .resetn(resetn),
      .syncn(syncn), .sclk(sclk), .din(din),
      .loadAllChannelsn(loadAllChannelsn), .dacCode(dacCode),
      .inputCode(inputCode), .powerMode(powerMode),
      .loadTransparent(loadTransparent), .referencePin(referencePin));
   host_model host (.clk(clk), .syncn(syncn), .sclk(sclk), .din(din));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [140:0] seen, input logic [140:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Per-channel effects first, so update-all sees the fresh input
   task automatic apply(input logic [23:0] w);
      logic [2:0] c;
      c = w[21:19];
      for (int k = 0; k < 4; k++)
      begin
         if (w[18:16] == 3'h7 || w[18:16] == k[2:0])
         begin
            if (c inside {3'h0, 3'h2, 3'h3})
               mIn[k] = w[15:0];
            if (c == 3'h3 || (c == 3'h0 && mLt[k]))
               mDac[k] = w[15:0];
            if (c == 3'h1)
               mDac[k] = mIn[k];
         end
         if (c == 3'h2)
            mDac[k] = mIn[k];
         if (c == 3'h4 && w[k])
            mPm[k] = w[5:4];
         if (c == 3'h5)
         begin
            mIn[k]  = 16'h0000;
            mDac[k] = 16'h0000;
            mPm[k]  = w[0] ? 2'h0 : mPm[k];
         end
      end
      mLt  = (c == 3'h5 && w[0]) ? 4'h0 : (c == 3'h6) ? w[3:0] : mLt;
      mRef = (c == 3'h5 && w[0]) ? 1'b0 : (c == 3'h7) ? w[0] : mRef;
   endtask
   function automatic logic [140:0] expected();
      return {mDac[3], mDac[2], mDac[1], mDac[0], mIn[3], mIn[2], mIn[1],
         mIn[0], mPm[3], mPm[2], mPm[1], mPm[0], mLt, mRef};
   endfunction
   task automatic frame(input logic [23:0] w, input int n);
      host.send(w, n);
      if (n >= 24)
         apply(w);
      repeat (10) @(negedge clk);
   endtask
   `define OUTS {dacCode, inputCode, powerMode, loadTransparent, referencePin}
   initial
   begin
      resetn = 1'b0;
      loadAllChannelsn = 1'b1;
      n_fail = 0;
      compares = 0;
      apply(24'h28_0001);
      void'($urandom(32'h0000_4901));
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(negedge clk);
      check(`OUTS, expected());
      foreach (plan[j])
      begin
         frame(plan[j], 24);
         check(`OUTS, expected());
      end
      for (int j = 0; j < 16; j++)
      begin
         v = {2'h0, 3'($urandom_range(0, 7)), 3'($urandom_range(0, 4)),
            16'($urandom)};
         v[18:16] = (v[18:16] == 3'h4) ? 3'h7 : v[18:16];
         frame(v, (j < 12) ? 24 : (j < 14) ? $urandom_range(1, 23) : 28);
         check(`OUTS, expected());
      end
      frame({8'h00, 16'($urandom)}, 24);
      @(posedge clk) loadAllChannelsn <= 1'b0;
      // Three-stage pin filter plus level register before the copy lands
      repeat (8) @(negedge clk);
      for (int k = 0; k < 4; k++)
         mDac[k] = mIn[k];
      check(`OUTS, expected());
      @(posedge clk) loadAllChannelsn <= 1'b1;
      results();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
